// file: pnsr_consts.svh
// offsets, field positions and reset values of the page/status bank
`ifndef PNSR_CONSTS_SVH
`define PNSR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PNSR_NP_OFS      8'h9c
`define PNSR_STS_OFS     8'hc0
`define PNSR_EVT_STS_OFS 8'he0
`define PNSR_EVT_MSK_OFS 8'he4

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define PNSR_NP_RESET    16'h2001
`define PNSR_NP_WMASK    16'hb7ff
`define PNSR_STS_RESET   16'h0000
`define PNSR_EVT_RESET   5'h00

// ----------------------------------------------------------------
// summary status field positions
// ----------------------------------------------------------------
`define PNSR_STS_RXERR   13
`define PNSR_STS_POL     12
`define PNSR_STS_FCAR    11
`define PNSR_STS_SIGDET  10
`define PNSR_STS_DLOCK   9
`define PNSR_STS_PAGE    8
`define PNSR_STS_INT     7

// ----------------------------------------------------------------
// event bit positions in the event status and mask registers
// ----------------------------------------------------------------
`define PNSR_EVT_RXERR   0
`define PNSR_EVT_FCAR    1
`define PNSR_EVT_PAGE    2
`define PNSR_EVT_SIGLOST 3
`define PNSR_EVT_PHYINT  4
`define PNSR_EVT_W       5

`endif

// file: pnsr_pkg.sv
// types shared by the next page and status register bank
package pnsr_pkg;

  // next page word as sent to the link partner
  typedef struct packed {
    logic        more_pages_request;
    logic        reserved;
    logic        message_page_select;
    logic        will_comply_ack;
    logic        transmit_toggle;
    logic [10:0] code;
  } pnsr_np_s;

  // pulse events from neighbouring phy logic
  typedef struct packed {
    logic rx_err;
    logic rx_err_cnt_rd;
    logic false_carrier;
    logic false_carrier_cnt_rd;
    logic page_rcvd;
    logic an_expansion_rd;
    logic phy_int;
  } pnsr_evt_s;

endpackage

// file: pnsr_regs.sv
// next page transmit and phy summary status registers with interrupt
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`include "pnsr_consts.svh"


module pnsr_regs
  import pnsr_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        lcw_done_i,
  input  wire logic        lcw_toggle_i,
  input  wire pnsr_evt_s   evt_i,
  input  wire logic        ten_mbps_polarity_i,
  input  wire logic        pmd_signal_detect_i,
  input  wire logic        pmd_descr_lock_i,
  output pnsr_np_s         next_page_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------

  logic rst_sync1_r;
  logic rst_n_r;

  // asynchronous assert, release after two clean edges
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_sync1_r <= 1'b0;
      rst_n_r     <= 1'b0;
    end
    else
    begin
      rst_sync1_r <= 1'b1;
      rst_n_r     <= rst_sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // pmd level synchronisers
  // ----------------------------------------------------------------

  // bit 0 signal detect, bit 1 descrambler lock
  logic [1:0] pmd_sync1_r;
  logic [1:0] pmd_live_r;
  logic       sd_prev_r;

  // pmd levels come from the analog side, so two flops first
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pmd_sync1_r <= 2'h0;
      pmd_live_r  <= 2'h0;
    end
    else
    begin
      pmd_sync1_r <= {pmd_descr_lock_i, pmd_signal_detect_i};
      pmd_live_r  <= pmd_sync1_r;
    end
  end

  // previous synced signal detect for the loss event
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      sd_prev_r <= 1'b0;
    else
      sd_prev_r <= pmd_live_r[0];
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  logic np_wr;
  logic sts_rd;
  logic evt_sts_wr;
  logic evt_msk_wr;
  logic sig_lost;

  // single cycle strobes qualified by address
  assign np_wr      = reg_wr_i && (reg_addr_i == `PNSR_NP_OFS);
  assign sts_rd     = reg_rd_i && (reg_addr_i == `PNSR_STS_OFS);
  assign evt_sts_wr = reg_wr_i && (reg_addr_i == `PNSR_EVT_STS_OFS);
  assign evt_msk_wr = reg_wr_i && (reg_addr_i == `PNSR_EVT_MSK_OFS);
  assign sig_lost   = sd_prev_r && !pmd_live_r[0];

  // ----------------------------------------------------------------
  // next page transmit register
  // ----------------------------------------------------------------

  // hard reset image of the whole word, split per field below
  localparam pnsr_np_s NP_DEF = pnsr_np_s'(`PNSR_NP_RESET);

  pnsr_np_s    np_wdata;
  pnsr_np_s    np_word;
  logic        np_more_r;
  logic        np_msg_r;
  logic        np_comply_r;
  logic        np_tog_r;
  logic [10:0] np_code_r;

  // write data seen through the field layout; masked bits never land
  assign np_wdata = pnsr_np_s'(reg_wdata_i & `PNSR_NP_WMASK);

  // more pages request, set by software when another page follows
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      np_more_r <= NP_DEF.more_pages_request;
    else if (np_wr)
      np_more_r <= np_wdata.more_pages_request;
  end

  // message page by default, unformatted once cleared
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      np_msg_r <= NP_DEF.message_page_select;
    else if (np_wr)
      np_msg_r <= np_wdata.message_page_select;
  end

  // will comply answer carried in the outgoing page
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      np_comply_r <= NP_DEF.will_comply_ack;
    else if (np_wr)
      np_comply_r <= np_wdata.will_comply_ack;
  end

  // toggle is hardware-owned; software writes cannot reach it
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      np_tog_r <= NP_DEF.transmit_toggle;
    else if (lcw_done_i)
      np_tog_r <= !lcw_toggle_i;
  end

  // code field: message code or free data, by message select
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      np_code_r <= NP_DEF.code;
    else if (np_wr)
      np_code_r <= np_wdata.code;
  end

  // reserved bit is a wired zero, so a write to it has nowhere to go
  always_comb
  begin
    np_word.more_pages_request  = np_more_r;
    np_word.reserved            = 1'b0;
    np_word.message_page_select = np_msg_r;
    np_word.will_comply_ack     = np_comply_r;
    np_word.transmit_toggle     = np_tog_r;
    np_word.code                = np_code_r;
  end

  // the page engine reads the same flops software sees
  assign next_page_o = np_word;

  // ----------------------------------------------------------------
  // latch-high status flags and the polarity copy
  // ----------------------------------------------------------------

  logic rx_err_lat_r;
  logic fcar_lat_r;
  logic page_lat_r;
  logic int_pend_r;
  logic pol_r;

  // set wins over the counter read in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rx_err_lat_r <= 1'b0;
    else if (evt_i.rx_err)
      rx_err_lat_r <= 1'b1;
    else if (evt_i.rx_err_cnt_rd)
      rx_err_lat_r <= 1'b0;
  end

  // false carrier flag, only its counter read clears it
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      fcar_lat_r <= 1'b0;
    else if (evt_i.false_carrier)
      fcar_lat_r <= 1'b1;
    else if (evt_i.false_carrier_cnt_rd)
      fcar_lat_r <= 1'b0;
  end

  // page flag follows the expansion copy, not our reads
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      page_lat_r <= 1'b0;
    else if (evt_i.page_rcvd)
      page_lat_r <= 1'b1;
    else if (evt_i.an_expansion_rd)
      page_lat_r <= 1'b0;
  end

  // pending cleared by the summary read that returns it
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      int_pend_r <= 1'b0;
    else if (evt_i.phy_int)
      int_pend_r <= 1'b1;
    else if (sts_rd)
      int_pend_r <= 1'b0;
  end

  // polarity is a plain copy; its owner clears it on its own read
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pol_r <= 1'b0;
    else
      pol_r <= ten_mbps_polarity_i;
  end

  // ----------------------------------------------------------------
  // latch-low status flags
  // ----------------------------------------------------------------

  // bit 0 signal detect, bit 1 descrambler lock
  logic [1:0] ll_r;

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl = gl + 1)
    begin : g_ll
      // a drop beats a read, so a glitch during the read is kept
      always_ff @(posedge core_clk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
          ll_r[gl] <= 1'b0;
        else if (!pmd_live_r[gl])
          ll_r[gl] <= 1'b0;
        else if (sts_rd)
          ll_r[gl] <= 1'b1;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // event status and mask registers
  // ----------------------------------------------------------------

  logic [`PNSR_EVT_W-1:0] evt_set;
  logic [`PNSR_EVT_W-1:0] evt_sts_r;
  logic [`PNSR_EVT_W-1:0] evt_msk_r;

  // events that feed the interrupt line
  always_comb
  begin
    evt_set                    = `PNSR_EVT_RESET;
    evt_set[`PNSR_EVT_RXERR]   = evt_i.rx_err;
    evt_set[`PNSR_EVT_FCAR]    = evt_i.false_carrier;
    evt_set[`PNSR_EVT_PAGE]    = evt_i.page_rcvd;
    evt_set[`PNSR_EVT_SIGLOST] = sig_lost;
    evt_set[`PNSR_EVT_PHYINT]  = evt_i.phy_int;
  end

  genvar ge;
  generate
    for (ge = 0; ge < `PNSR_EVT_W; ge = ge + 1)
    begin : g_evt
      // write one to clear; a new event in that cycle survives
      always_ff @(posedge core_clk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
          evt_sts_r[ge] <= 1'b0;
        else if (evt_set[ge])
          evt_sts_r[ge] <= 1'b1;
        else if (evt_sts_wr && reg_wdata_i[ge])
          evt_sts_r[ge] <= 1'b0;
      end
    end
  endgenerate

  // mask: 1 lets the matching event reach the interrupt
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      evt_msk_r <= `PNSR_EVT_RESET;
    else if (evt_msk_wr)
      evt_msk_r <= reg_wdata_i[`PNSR_EVT_W-1:0];
  end

  // registered so the pin is glitch free; lags status by one edge
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      irq_o <= 1'b0;
    else
      irq_o <= |(evt_sts_r & evt_msk_r);
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  logic [15:0] sts_word;
  logic [15:0] rdata_nxt;

  // summary word, reserved and low bits read as zero
  always_comb
  begin
    sts_word                  = `PNSR_STS_RESET;
    sts_word[`PNSR_STS_RXERR]  = rx_err_lat_r;
    sts_word[`PNSR_STS_POL]    = pol_r;
    sts_word[`PNSR_STS_FCAR]   = fcar_lat_r;
    sts_word[`PNSR_STS_SIGDET] = ll_r[0];
    sts_word[`PNSR_STS_DLOCK]  = ll_r[1];
    sts_word[`PNSR_STS_PAGE]   = page_lat_r;
    sts_word[`PNSR_STS_INT]    = int_pend_r;
  end

  // unmapped addresses answer zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `PNSR_NP_OFS:      rdata_nxt = 16'(np_word);
        `PNSR_STS_OFS:     rdata_nxt = sts_word;
        `PNSR_EVT_STS_OFS: rdata_nxt = {11'h000, evt_sts_r};
        `PNSR_EVT_MSK_OFS: rdata_nxt = {11'h000, evt_msk_r};
        default:           rdata_nxt = 16'h0000;
      endcase
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      reg_rdata_o <= 16'h0000;
    else
      reg_rdata_o <= rdata_nxt;
  end

endmodule

// file: pnsr_regs_chk.sv
// port assertions for the page/status register bank
`timescale 1ns/1ns
`include "pnsr_consts.svh"
// --------------------
// checker
// --------------------
module pnsr_regs_chk
  import pnsr_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        lcw_done_i,
  input wire logic        lcw_toggle_i,
  input wire pnsr_evt_s   evt_i,
  input wire logic        ten_mbps_polarity_i,
  input wire logic        pmd_signal_detect_i,
  input wire logic        pmd_descr_lock_i,
  input wire pnsr_np_s    next_page_o,
  input wire logic        irq_o
);
  // status read strobe; its data lands one cycle later
  logic sts_rd;
  assign sts_rd = reg_rd_i && reg_addr_i == `PNSR_STS_OFS;
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_sts_rsvd;
    sts_rd |=> reg_rdata_o[15:14] == 2'b00;
  endproperty
  a_sts_rsvd: assert property (p_sts_rsvd)
    else $error("status reserved bits set");
  property p_np_wr;
    reg_wr_i && reg_addr_i == `PNSR_NP_OFS |=>
      {next_page_o[15:12], next_page_o[10:0]} == {$past(reg_wdata_i[15]),
      1'b0, $past(reg_wdata_i[13:12]), $past(reg_wdata_i[10:0])};
  endproperty
  a_np_wr: assert property (p_np_wr)
    else $error("next page write not taken");
  property p_toggle;
    lcw_done_i |=> next_page_o.transmit_toggle == !$past(lcw_toggle_i);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle not inverse of last word");
  property p_rxerr;
    evt_i.rx_err ##1 !evt_i.rx_err_cnt_rd ##1 sts_rd |=> reg_rdata_o[13];
  endproperty
  a_rxerr: assert property (p_rxerr)
    else $error("receive error latch missed");
  property p_fcar_clr;
    evt_i.false_carrier_cnt_rd && !evt_i.false_carrier
      ##1 (!evt_i.false_carrier) [*2] ##1 sts_rd |=> !reg_rdata_o[11];
  endproperty
  a_fcar_clr: assert property (p_fcar_clr)
    else $error("false carrier latch not cleared");
  property p_int_clr;
    sts_rd && !evt_i.phy_int ##1 !evt_i.phy_int ##1 sts_rd
      |=> !reg_rdata_o[7];
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt pending survived read");
  property p_pol;
    sts_rd |=> reg_rdata_o[12] == $past(ten_mbps_polarity_i, 2);
  endproperty
  a_pol: assert property (p_pol)
    else $error("polarity bit wrong");
  // a drop held five cycles outlasts the two-flop sync
  property p_sig_low;
    !pmd_signal_detect_i [*5] ##0 sts_rd |=> !reg_rdata_o[10];
  endproperty
  a_sig_low: assert property (p_sig_low)
    else $error("signal detect not latched low");
endmodule

bind pnsr_regs pnsr_regs_chk i_chk (.core_clk_i, .nrst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .lcw_done_i,
  .lcw_toggle_i, .evt_i, .ten_mbps_polarity_i, .pmd_signal_detect_i,
  .pmd_descr_lock_i, .next_page_o, .irq_o);

// file: tb.sv
// self-checking bench for the page/status register bank
`timescale 1ns/1ns
`include "pnsr_consts.svh"
// --------------------
// bench top
// --------------------
module tb
  import pnsr_pkg::*;
;
  localparam logic [7:0] NPO = `PNSR_NP_OFS;
  localparam logic [7:0] STO = `PNSR_STS_OFS;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        lcw = 1'b0;
  logic        ltg = 1'b0;
  logic        pol = 1'b0;
  logic        sd = 1'b0;
  logic        dl = 1'b0;
  logic        tog = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdat = 16'h0000;
  pnsr_evt_s   evt = '0;
  logic [15:0] rdat;
  pnsr_np_s    np;
  logic        irq;
  logic [15:0] d;
  logic [15:0] v;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;

  pnsr_regs i_dut (
    .core_clk_i          (clk),
    .nrst_i              (nrst),
    .reg_addr_i          (addr),
    .reg_wdata_i         (wdat),
    .reg_wr_i            (wr),
    .reg_rd_i            (rd),
    .reg_rdata_o         (rdat),
    .lcw_done_i          (lcw),
    .lcw_toggle_i        (ltg),
    .evt_i               (evt),
    .ten_mbps_polarity_i (pol),
    .pmd_signal_detect_i (sd),
    .pmd_descr_lock_i    (dl),
    .next_page_o         (np),
    .irq_o               (irq)
  );

  // 25 MHz core clock
  always #20 clk = ~clk;

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      close_out;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bus cycles: strobes last one cycle, read data the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdat;
  endtask
  task automatic pulse(input pnsr_evt_s x);
    @(posedge clk);
    evt <= x;
    @(posedge clk);
    evt <= '0;
  endtask
  // let registered outputs such as irq settle
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(78));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(NPO, v);
    chk(v, 16'h2001);
    rd_reg(STO, v);
    chk(v, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    $display("reset test done");
    // toggle exchange, then a write; the first write is all ones
    for (int i = 0; i < 8; i++)
    begin
      d = 16'($urandom);
      @(posedge clk);
      lcw <= 1'b1;
      ltg <= d[0];
      @(posedge clk);
      lcw <= 1'b0;
      tog = ~d[0];
      d = (i == 0) ? 16'hffff : 16'($urandom);
      wr_reg(NPO, d);
      rd_reg(NPO, v);
      chk(v, d & 16'hb7ff | {4'h0, tog, 11'h0});
      chk(np, d & 16'hb7ff | {4'h0, tog, 11'h0});
    end
    $display("next page test done");
    @(posedge clk);
    pol <= 1'b1;
    pulse(7'h55);
    rd_reg(STO, v);
    chk(v, 16'h3980);
    rd_reg(STO, v);
    chk(v, 16'h3900);
    wr_reg(STO, 16'hffff);
    pulse(7'h2a);
    @(posedge clk);
    pol <= 1'b0;
    rd_reg(STO, v);
    chk(v, 16'h0000);
    // error and its counter read in one cycle: the error wins
    pulse(7'h60);
    rd_reg(STO, v);
    chk(v, 16'h2000);
    pulse(7'h20);
    $display("status test done");
    @(posedge clk);
    sd <= 1'b1;
    dl <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg(STO, v);
    chk(v, 16'h0000);
    rd_reg(STO, v);
    chk(v, 16'h0600);
    @(posedge clk);
    sd <= 1'b0;
    dl <= 1'b0;
    @(posedge clk);
    sd <= 1'b1;
    dl <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg(STO, v);
    chk(v, 16'h0000);
    rd_reg(STO, v);
    chk(v, 16'h0600);
    $display("latch low test done");
    wr_reg(8'he0, 16'h001f);
    wr_reg(8'he4, 16'h0001);
    pulse(7'h40);
    settle;
    chk({15'h0, irq}, 16'h0001);
    wr_reg(8'he4, 16'h0000);
    settle;
    chk({15'h0, irq}, 16'h0000);
    wr_reg(8'he4, 16'h0001);
    settle;
    chk({15'h0, irq}, 16'h0001);
    wr_reg(8'he0, 16'h0001);
    settle;
    chk({15'h0, irq}, 16'h0000);
    rd_reg(8'he0, v);
    chk(v, 16'h0000);
    rd_reg(8'h10, v);
    chk(v, 16'h0000);
    $display("interrupt test done");
    close_out;
  end
endmodule
